// ==== verilog/qpc_top.sv ====
// Purpose: Quadrature phase counting on channels 1 and 2 with a linked
//          channel 0 for speed and position capture.
// Assumes: Register port is word addressed; inputs are clean levels.
// Notes:   Outside phase mode channels 1 and 2 count prescaled clock.
//
// Functional notes
// R1 - Phase mode exists only on channels 1, 2.
// R2 - Phase mode ignores prescaler and edge select.
// R3 - Counter bidirectional; clear, capture, interrupts still work.
// R4 - Up wrap past maximum sets overflow flag.
// R5 - Down wrap below zero sets underflow flag.
// R6 - Direction flag shows current count direction.
// R7 - Channel 1 uses pins 1,2; channel 2 pins 3,4.
// R8 - Mode field selects; run bit starts counting.
// R9 - Four sub-modes with own count conditions.
// R10 - Sub-mode 1 increment conditions.
// R11 - Sub-mode 1 decrement conditions, four counts per cycle.
// R12 - Sub-mode 2 counts only on A falling.
// R13 - Sub-mode 3: A fall up, B fall down.
// R14 - Sub-mode 4 counts only on B edges.
// R15 - Channel 0 B captures on channel 1 count clock.
// R16 - Channel 1 A/B capture on channel 0 matches.
// R17 - Channel 1 clock settings void in phase mode.
// R18 - Counters are 16 bits wide.
// R19 - Synchronise phase inputs, detect edges by history.
`timescale 1ns/1ps
module qpc_top #(
   parameter int PSC_W = qpc_pkg::PSC_BITS
) (
   input  wire logic                        ref_clk,
   input  wire logic                        srst,
   input  wire logic [qpc_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [qpc_pkg::CNT_W-1:0]   reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [qpc_pkg::CNT_W-1:0]   reg_rdata,
   input  wire logic                        phase_in_1,
   input  wire logic                        phase_in_2,
   input  wire logic                        phase_in_3,
   input  wire logic                        phase_in_4,
   output logic                             irq
);
   localparam int CW = qpc_pkg::CNT_W;

   typedef struct packed {
      logic [qpc_pkg::NRUN-1:0]          run;
      logic [qpc_pkg::NPH-1:0][CW-1:0]   mode;
      logic [qpc_pkg::NPH-1:0][CW-1:0]   cnt;
      logic [qpc_pkg::NPH-1:0]           dir;
      logic [qpc_pkg::EV_W-1:0]          stat;
      logic [qpc_pkg::EV_W-1:0]          irq_en;
      logic [CW-1:0]                     cnt0;
      logic [CW-1:0]                     gr0a;
      logic [CW-1:0]                     gr0c;
      logic [CW-1:0]                     gr0b;
      logic [CW-1:0]                     gr0d;
      logic [CW-1:0]                     cap1a;
      logic [CW-1:0]                     cap1b;
      logic [2:0]                        link;
      logic [PSC_W-1:0]                  psc;
      logic [CW-1:0]                     rdata;
   } qpc_top_s;

   qpc_top_s                   st;
   qpc_top_s                   next_st;
   logic [qpc_pkg::NPH-1:0]    ph_a;
   logic [qpc_pkg::NPH-1:0]    ph_b;
   logic [qpc_pkg::NPH-1:0]    dec_up;
   logic [qpc_pkg::NPH-1:0]    dec_dn;
   logic [qpc_pkg::NPH-1:0]    is_ph;
   logic [qpc_pkg::NPH-1:0]    up_ev;
   logic [qpc_pkg::NPH-1:0]    dn_ev;
   logic [qpc_pkg::NPH-1:0]    clr_ev;
   logic [qpc_pkg::NPH-1:0]    wr_cnt;
   logic [qpc_pkg::EV_W-1:0]   ev;
   logic                       cmp_a;
   logic                       cmp_c;
   logic                       cap1_a_ev;
   logic                       cap1_b_ev;
   logic                       cap0_b_ev;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Write hit on one register index.
   function automatic logic wr_hit(input logic [qpc_pkg::ADDR_W-1:0] idx);
      wr_hit = reg_wr && (reg_addr == idx);
   endfunction

   // Phase mode is any code whose upper two mode bits carry the tag.
   function automatic logic phase_sel(input logic [CW-1:0] m);
      phase_sel = (m[qpc_pkg::MODE_LSB+2 +: 2] == qpc_pkg::PHASE_TAG);
   endfunction

   // Prescaler tick: divide by two to the power of the select field.
   function automatic logic psc_tick(input logic [PSC_W-1:0] p, input logic [2:0] sel);
      logic [PSC_W-1:0] mask;
      mask = PSC_W'((1 << sel) - 1);
      psc_tick = &(p | ~mask);
   endfunction

   // ------------------------------------------------------------
   // Phase decoders, one per phase-capable channel
   // ------------------------------------------------------------
   assign ph_a = {phase_in_3, phase_in_1}; // [R7]
   assign ph_b = {phase_in_4, phase_in_2}; // [R7]

   // Only channels 1 and 2 own a decoder, so channel 0 cannot phase count.
   generate
      for (genvar g = 0; g < qpc_pkg::NPH; g++) begin : g_ch
         qpc_phase_if pif ();
         assign pif.ph_a = ph_a[g];
         assign pif.ph_b = ph_b[g];
         assign pif.sub_mode = qpc_pkg::qpc_sub_e'(st.mode[g][qpc_pkg::MODE_LSB +: 2]); // [R9]
         assign dec_up[g] = pif.up;
         assign dec_dn[g] = pif.dn;
         qpc_phase_dec u_dec (
            .ref_clk (ref_clk),
            .srst    (srst),
            .pif     (pif)
         ); // [R1]

         // In phase mode only decoder pulses clock the counter; the
         // prescaler field, even with all three select bits set, is ignored.
         assign is_ph[g] = phase_sel(st.mode[g]); // [R8]
         assign up_ev[g] = st.run[g+1] && (is_ph[g] ? (dec_up[g] && !dec_dn[g])
            : psc_tick(st.psc, st.mode[g][qpc_pkg::PSC_LSB +: 3])); // [R2] [R17]
         assign dn_ev[g] = st.run[g+1] && is_ph[g] && dec_dn[g] && !dec_up[g]; // [R3]
         assign wr_cnt[g] = wr_hit(qpc_pkg::A_CNT1 + qpc_pkg::ADDR_W'(g));
      end
   endgenerate

   // ------------------------------------------------------------
   // Channel 0 matches and cross-channel capture triggers
   // ------------------------------------------------------------
   assign cmp_a = st.run[qpc_pkg::RUN0] && (st.cnt0 == st.gr0a);
   assign cmp_c = st.run[qpc_pkg::RUN0] && (st.cnt0 == st.gr0c);
   assign cap1_a_ev = st.link[qpc_pkg::LK_CAP1] && cmp_a; // [R16]
   assign cap1_b_ev = st.link[qpc_pkg::LK_CAP1] && cmp_c; // [R16]
   assign cap0_b_ev = st.link[qpc_pkg::LK_CAP0B] && (up_ev[0] || dn_ev[0]); // [R15]

   // Clear source keeps working in phase mode; only channel 1 has a
   // capture A trigger, so channel 2 never clears this way.
   assign clr_ev[0] = (st.mode[0][qpc_pkg::CLR_LSB +: 2] == qpc_pkg::CLR_CAPA) && cap1_a_ev; // [R3]
   assign clr_ev[1] = 1'b0;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      ev = '0;
      next_st.psc = st.psc + PSC_W'(1);

      // Control registers written by software.
      if (wr_hit(qpc_pkg::A_START)) begin
         next_st.run = reg_wdata[qpc_pkg::NRUN-1:0]; // [R8]
      end
      if (wr_hit(qpc_pkg::A_MODE1)) begin
         next_st.mode[0] = reg_wdata;
      end
      if (wr_hit(qpc_pkg::A_MODE2)) begin
         next_st.mode[1] = reg_wdata;
      end
      if (wr_hit(qpc_pkg::A_IRQEN)) begin
         next_st.irq_en = reg_wdata[qpc_pkg::EV_W-1:0];
      end
      if (wr_hit(qpc_pkg::A_LINK)) begin
         next_st.link = reg_wdata[2:0];
      end
      if (wr_hit(qpc_pkg::A_GR0A)) begin
         next_st.gr0a = reg_wdata;
      end
      if (wr_hit(qpc_pkg::A_GR0C)) begin
         next_st.gr0c = reg_wdata;
      end

      // Channels 1 and 2: a software write beats a count in that cycle.
      for (int i = 0; i < qpc_pkg::NPH; i++) begin
         if (wr_cnt[i]) begin
            next_st.cnt[i] = reg_wdata;
         end else if (clr_ev[i]) begin
            next_st.cnt[i] = qpc_pkg::CNT_RST; // [R3]
         end else if (up_ev[i]) begin
            next_st.cnt[i] = st.cnt[i] + qpc_pkg::CNT_ONE; // [R18]
            ev[qpc_pkg::ST_OVF1 + 2*i] = (st.cnt[i] == qpc_pkg::CNT_MAX); // [R4]
         end else if (dn_ev[i]) begin
            next_st.cnt[i] = st.cnt[i] - qpc_pkg::CNT_ONE; // [R18]
            ev[qpc_pkg::ST_OVF1 + 2*i + 1] = (st.cnt[i] == qpc_pkg::CNT_RST); // [R5]
         end
         if (up_ev[i] || dn_ev[i]) begin
            next_st.dir[i] = up_ev[i]; // [R6]
         end
      end

      // Channel 0 runs on the clock and may clear on its C match.
      if (wr_hit(qpc_pkg::A_CNT0)) begin
         next_st.cnt0 = reg_wdata;
      end else if (st.link[qpc_pkg::LK_CLR0C] && cmp_c) begin
         next_st.cnt0 = qpc_pkg::CNT_RST;
      end else if (st.run[qpc_pkg::RUN0]) begin
         next_st.cnt0 = st.cnt0 + qpc_pkg::CNT_ONE;
      end

      // Buffered pulse capture: the old capture moves to the buffer.
      if (cap0_b_ev) begin
         next_st.gr0b = st.cnt0; // [R15]
         next_st.gr0d = st.gr0b; // [R15]
         ev[qpc_pkg::ST_CAP0B] = 1'b1;
      end
      if (cap1_a_ev) begin
         next_st.cap1a = st.cnt[0]; // [R16]
         ev[qpc_pkg::ST_CAP1A] = 1'b1;
      end
      if (cap1_b_ev) begin
         next_st.cap1b = st.cnt[0]; // [R16]
         ev[qpc_pkg::ST_CAP1B] = 1'b1;
      end

      // Sticky status: write one to clear, a new event wins the cycle.
      if (wr_hit(qpc_pkg::A_STAT)) begin
         next_st.stat = st.stat & ~reg_wdata[qpc_pkg::EV_W-1:0];
      end
      next_st.stat = next_st.stat | ev; // [R4] [R5] [R3]

      // Read data stand only in the cycle after the strobe.
      next_st.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            qpc_pkg::A_START: next_st.rdata = CW'(st.run);
            qpc_pkg::A_MODE1: next_st.rdata = st.mode[0];
            qpc_pkg::A_MODE2: next_st.rdata = st.mode[1];
            qpc_pkg::A_CNT1: next_st.rdata = st.cnt[0];
            qpc_pkg::A_CNT2: next_st.rdata = st.cnt[1];
            qpc_pkg::A_STAT: begin
               next_st.rdata = CW'(st.stat);
               next_st.rdata[qpc_pkg::ST_DIR1 +: qpc_pkg::NPH] = st.dir; // [R6]
            end
            qpc_pkg::A_IRQEN: next_st.rdata = CW'(st.irq_en);
            qpc_pkg::A_CNT0: next_st.rdata = st.cnt0;
            qpc_pkg::A_GR0A: next_st.rdata = st.gr0a;
            qpc_pkg::A_GR0C: next_st.rdata = st.gr0c;
            qpc_pkg::A_GR0B: next_st.rdata = st.gr0b;
            qpc_pkg::A_GR0D: next_st.rdata = st.gr0d;
            qpc_pkg::A_CAP1A: next_st.rdata = st.cap1a;
            qpc_pkg::A_CAP1B: next_st.rdata = st.cap1b;
            qpc_pkg::A_LINK: next_st.rdata = CW'(st.link);
            default: next_st.rdata = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Interrupt is a level that follows the masked sticky bits.
   assign irq = |(st.stat & st.irq_en); // [R3]
   assign reg_rdata = st.rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking dcb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_ovf_wrap: assert property (up_ev[0] && !wr_cnt[0] && !clr_ev[0] && (st.cnt[0] == qpc_pkg::CNT_MAX)
      |=> st.stat[qpc_pkg::ST_OVF1] && (st.cnt[0] == qpc_pkg::CNT_RST)) else $error("overflow not flagged"); // [R4]
   a_unf_wrap: assert property (dn_ev[0] && !wr_cnt[0] && !clr_ev[0] && (st.cnt[0] == qpc_pkg::CNT_RST)
      |=> st.stat[qpc_pkg::ST_OVF1+1] && (st.cnt[0] == qpc_pkg::CNT_MAX)) else $error("underflow not flagged"); // [R5]
   a_dir_follow: assert property ((up_ev[1] || dn_ev[1])
      |=> (st.dir[1] == $past(up_ev[1]))) else $error("direction flag wrong"); // [R6]
   a_stop_hold: assert property (!st.run[1] && !wr_cnt[0] && !clr_ev[0]
      |=> $stable(st.cnt[0])) else $error("stopped counter moved"); // [R8]
   a_phase_step: assert property (is_ph[1] && dn_ev[1] && !wr_cnt[1]
      |=> (st.cnt[1] == $past(st.cnt[1]) - qpc_pkg::CNT_ONE)) else $error("phase step wrong"); // [R3]
   a_ph_ignore_psc: assert property (is_ph[0] && st.run[1] && !dec_up[0] && !dec_dn[0]
      |-> !up_ev[0] && !dn_ev[0]) else $error("prescaler counted in phase mode"); // [R2]
   a_cap_pos: assert property (cap1_a_ev
      |=> (st.cap1a == $past(st.cnt[0])) && st.stat[qpc_pkg::ST_CAP1A]) else $error("position capture lost"); // [R16]
   a_cap_pulse: assert property (cap0_b_ev ##1 1'b1
      |-> (st.gr0d == $past(st.gr0b)) && (st.gr0b == $past(st.cnt0))) else $error("pulse capture wrong"); // [R15]
   a_irq_level: assert property (st.stat[qpc_pkg::ST_CAP0B] && st.irq_en[qpc_pkg::ST_CAP0B]
      |-> irq) else $error("interrupt not raised"); // [R3]
   a_clr_capa: assert property (clr_ev[0] && !wr_cnt[0] // [R3]
      |=> (st.cnt[0] == qpc_pkg::CNT_RST)) else $error("capture clear missed");
   a_ch2_ovf: assert property (up_ev[1] && !wr_cnt[1] && (st.cnt[1] == qpc_pkg::CNT_MAX) // [R4]
      |=> st.stat[qpc_pkg::ST_OVF1+2]) else $error("channel 2 overflow not flagged");
endmodule

// ==== verilog/qpc_pkg.sv ====
// Purpose: Shared constants and types of the quadrature phase counter.
// Assumes: Word-addressed register port, 16-bit data.
// Notes:   Every offset, field position and reset value lives here.
package qpc_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int ADDR_W = 4;
   localparam int NPH = 2;
   localparam int NRUN = 3;
   localparam int EV_W = 7;
   localparam int PSC_BITS = 8;

   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_START = 4'h0;
   localparam logic [ADDR_W-1:0] A_MODE1 = 4'h1;
   localparam logic [ADDR_W-1:0] A_MODE2 = 4'h2;
   localparam logic [ADDR_W-1:0] A_CNT1 = 4'h3;
   localparam logic [ADDR_W-1:0] A_CNT2 = 4'h4;
   localparam logic [ADDR_W-1:0] A_STAT = 4'h5;
   localparam logic [ADDR_W-1:0] A_IRQEN = 4'h6;
   localparam logic [ADDR_W-1:0] A_CNT0 = 4'h7;
   localparam logic [ADDR_W-1:0] A_GR0A = 4'h8;
   localparam logic [ADDR_W-1:0] A_GR0C = 4'h9;
   localparam logic [ADDR_W-1:0] A_GR0B = 4'hA;
   localparam logic [ADDR_W-1:0] A_GR0D = 4'hB;
   localparam logic [ADDR_W-1:0] A_CAP1A = 4'hC;
   localparam logic [ADDR_W-1:0] A_CAP1B = 4'hD;
   localparam logic [ADDR_W-1:0] A_LINK = 4'hE;

   // ------------------------------------------------------------
   // Fields of the channel mode register and codes
   // ------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int PSC_LSB = 4;
   localparam int CLR_LSB = 7;
   localparam logic [1:0] PHASE_TAG = 2'h1;
   localparam logic [1:0] CLR_CAPA = 2'h1;
   typedef enum logic [1:0] {
      QPC_SUB1 = 2'h0,
      QPC_SUB2 = 2'h1,
      QPC_SUB3 = 2'h2,
      QPC_SUB4 = 2'h3
   } qpc_sub_e;

   // ------------------------------------------------------------
   // Status, start and link bit positions
   // ------------------------------------------------------------
   localparam int ST_OVF1 = 0;
   localparam int ST_CAP1A = 4;
   localparam int ST_CAP1B = 5;
   localparam int ST_CAP0B = 6;
   localparam int ST_DIR1 = 8;
   localparam int RUN0 = 0;
   localparam int LK_CAP0B = 0;
   localparam int LK_CAP1 = 1;
   localparam int LK_CLR0C = 2;

   // ------------------------------------------------------------
   // Values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage

// ==== verilog/qpc_phase_if.sv ====
// Purpose: Carrier between a channel and its phase decoder.
// Assumes: One instance per phase-counting channel.
// Notes:   up and dn are one-cycle pulses from the decoder.
`timescale 1ns/1ps
interface qpc_phase_if;
   logic             ph_a;
   logic             ph_b;
   qpc_pkg::qpc_sub_e sub_mode;
   logic             up;
   logic             dn;
   modport dec (input ph_a, input ph_b, input sub_mode, output up, output dn);
   modport user (output ph_a, output ph_b, output sub_mode, input up, input dn);
endinterface

// ==== verilog/qpc_phase_dec.sv ====
// Purpose: Synchronise two phase inputs and decode count pulses.
// Assumes: Encoder edges are slower than three clock cycles.
// Notes:   Both up and dn may pulse in one cycle; the user drops that.
`timescale 1ns/1ps
module qpc_phase_dec (
   input  wire logic ref_clk,
   input  wire logic srst,
   qpc_phase_if.dec  pif
);
   typedef struct packed {
      logic a1;
      logic a2;
      logic ap;
      logic b1;
      logic b2;
      logic bp;
   } qpc_dec_s;

   qpc_dec_s st;
   qpc_dec_s next_st;
   logic     a;
   logic     b;
   logic     ar;
   logic     af;
   logic     br;
   logic     bf;

   // ------------------------------------------------------------
   // Synchroniser and edge history
   // ------------------------------------------------------------
   // The first stage feeds only the second stage, never the decoder.
   always_comb begin
      next_st = st;
      next_st.a1 = pif.ph_a;
      next_st.a2 = st.a1;
      next_st.ap = st.a2;
      next_st.b1 = pif.ph_b;
      next_st.b2 = st.b1;
      next_st.bp = st.b2;
   end

   // Registers the history; a pin high at reset shows one rising edge.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Edges come from the current and previous sampled levels.
   assign a = st.a2;
   assign b = st.b2;
   assign ar = a & ~st.ap; // [R19]
   assign af = ~a & st.ap; // [R19]
   assign br = b & ~st.bp;
   assign bf = ~b & st.bp;

   // ------------------------------------------------------------
   // Counting conditions per sub-mode
   // ------------------------------------------------------------
   always_comb begin
      unique case (pif.sub_mode)
         qpc_pkg::QPC_SUB1: begin
            pif.up = (br & a) | (bf & ~a) | (ar & ~b) | (af & b); // [R10]
            pif.dn = (bf & a) | (br & ~a) | (ar & b) | (af & ~b); // [R11]
         end
         qpc_pkg::QPC_SUB2: begin
            pif.up = af & b; // [R12]
            pif.dn = af & ~b; // [R12]
         end
         qpc_pkg::QPC_SUB3: begin
            pif.up = af & b; // [R13]
            pif.dn = bf & a; // [R13]
         end
         qpc_pkg::QPC_SUB4: begin
            pif.up = (br & a) | (bf & ~a); // [R14]
            pif.dn = (bf & a) | (br & ~a); // [R14]
         end
      endcase
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking dcb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_sub2_afall: assert property ((pif.sub_mode == qpc_pkg::QPC_SUB2) && (pif.up || pif.dn)
      |-> (st.ap && !st.a2 && (pif.up == st.b2))) else $error("sub-mode 2 count without A fall"); // [R12]
   a_sub3_bfall: assert property ((pif.sub_mode == qpc_pkg::QPC_SUB3) && pif.dn
      |-> (st.bp && !st.b2 && st.a2)) else $error("sub-mode 3 down without B fall"); // [R13]
   a_sub4_aedge: assert property ((pif.sub_mode == qpc_pkg::QPC_SUB4) && (st.a2 != st.ap) && (st.b2 == st.bp)
      |-> !pif.up && !pif.dn) else $error("sub-mode 4 counted an A edge"); // [R14]
endmodule

// ==== verification/qpc_enc_model.sv ====
// Purpose: Two-phase incremental encoder that drives one pair of phase pins.
// Assumes: Gap between edges is at least 3 clock cycles.
// Notes:   Forward steps make A lead B; backward steps make B lead A.
`timescale 1ns/1ps
module qpc_enc_model (
   input  wire logic ref_clk,
   output logic      ph_a,
   output logic      ph_b
);
   logic [1:0] pos;

   // Both pins idle low, matching the decoder history after reset.
   initial begin
      pos  = 2'h0;
      ph_a = 1'b0;
      ph_b = 1'b0;
   end

   // One quadrature step per call loop; a larger gap models a slow shaft.
   task automatic move(input int steps, input int gap);
      int n;
      n = (steps < 0) ? -steps : steps;
      repeat (n) begin
         @(posedge ref_clk);
         pos = (steps > 0) ? pos + 2'h1 : pos - 2'h1;
         ph_a <= pos[1] ^ pos[0];
         ph_b <= pos[1];
         repeat (gap) @(posedge ref_clk);
      end
      // Let the synchroniser and edge history catch up before anyone reads.
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

// ==== verification/tb_quadrature_phase_counter.sv ====
// Purpose: Self-checking bench of the quadrature phase counter.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes:   Two encoder models drive the channel 1 and channel 2 pins.
`timescale 1ns/1ps
module tb_quadrature_phase_counter;
   logic        ref_clk = 1'b0;
   logic        srst    = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        ph1, ph2, ph3, ph4, irq;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc = 0;

   qpc_top dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_in_1(ph1),
      .phase_in_2(ph2), .phase_in_3(ph3), .phase_in_4(ph4), .irq(irq));
   qpc_enc_model enc1 (.ref_clk(ref_clk), .ph_a(ph1), .ph_b(ph2));
   qpc_enc_model enc2 (.ref_clk(ref_clk), .ph_a(ph3), .ph_b(ph4));

   // ---------------------------------------------------------------
   // Clock, timeout and verdict
   // ---------------------------------------------------------------
   always #5 ref_clk = ~ref_clk;

   // A hung handshake would otherwise run forever; the whole run needs far less.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Register port and comparison helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic peek(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(d, e);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      peek(qpc_pkg::A_CNT1, 16'h0000);
      peek(qpc_pkg::A_STAT, 16'h0000);
      peek(4'hF, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
   endtask

   // Both channels run the same sub-mode with the prescale field set to all
   // ones; enc1 turns forward, enc2 backward, so a swapped pin pair shows.
   task automatic t_submodes();
      int fwd[4] = '{4, 1, 1, 2};
      logic [15:0] s;
      for (int m = 0; m < 4; m++) begin
         wr(qpc_pkg::A_START, 16'h0000);
         wr(qpc_pkg::A_CNT1, 16'h0000);
         wr(qpc_pkg::A_CNT2, 16'h0000);
         wr(qpc_pkg::A_MODE1, 16'h0074 + 16'(m));
         wr(qpc_pkg::A_MODE2, 16'h0074 + 16'(m));
         wr(qpc_pkg::A_START, 16'h0006);
         enc1.move(4, 3 + m);
         enc2.move(-4, 9);
         peek(qpc_pkg::A_CNT1, 16'(fwd[m]));
         peek(qpc_pkg::A_CNT2, 16'(-fwd[m]));
         rd(qpc_pkg::A_STAT, s);
         chk({14'h0, s[9:8]}, 16'h0001);
         enc1.move(-4, 3);
         peek(qpc_pkg::A_CNT1, 16'h0000);
      end
      wr(qpc_pkg::A_START, 16'h0000);
      enc1.move(4, 3);
      peek(qpc_pkg::A_CNT1, 16'h0000);
   endtask

   // Wrap both ways on channel 1 and walk the interrupt through mask and clear.
   task automatic t_wrap();
      logic [15:0] s;
      wr(qpc_pkg::A_STAT, 16'h00FF);
      wr(qpc_pkg::A_IRQEN, 16'h0000);
      wr(qpc_pkg::A_MODE1, 16'h0004);
      wr(qpc_pkg::A_START, 16'h0002);
      enc1.move(-1, 3);
      peek(qpc_pkg::A_CNT1, 16'hFFFF);
      rd(qpc_pkg::A_STAT, s);
      chk({14'h0, s[1:0]}, 16'h0002);
      chk({15'h0, irq}, 16'h0000);
      wr(qpc_pkg::A_IRQEN, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      enc1.move(1, 3);
      peek(qpc_pkg::A_CNT1, 16'h0000);
      wr(qpc_pkg::A_STAT, 16'h0002);
      chk({15'h0, irq}, 16'h0000);
      peek(qpc_pkg::A_STAT, 16'h0101);
   endtask

   // Channel 0 matches capture the position; channel 1 counts capture channel 0.
   task automatic t_link();
      logic [15:0] b;
      wr(qpc_pkg::A_START, 16'h0000);
      wr(qpc_pkg::A_CNT1, 16'h1234);
      wr(qpc_pkg::A_CNT0, 16'h0000);
      wr(qpc_pkg::A_GR0A, 16'h0005);
      wr(qpc_pkg::A_GR0C, 16'h0009);
      wr(qpc_pkg::A_LINK, 16'h0003);
      wr(qpc_pkg::A_STAT, 16'h00FF);
      wr(qpc_pkg::A_START, 16'h0003);
      repeat (20) @(posedge ref_clk);
      peek(qpc_pkg::A_CAP1A, 16'h1234);
      peek(qpc_pkg::A_CAP1B, 16'h1234);
      enc1.move(1, 3);
      peek(qpc_pkg::A_CNT1, 16'h1235);
      rd(qpc_pkg::A_GR0B, b);
      enc1.move(1, 3);
      peek(qpc_pkg::A_GR0D, b);
      peek(qpc_pkg::A_STAT, 16'h0170);
   endtask

   // Channel 0 A matches clear channel 1 through its capture; C matches wrap channel 0.
   task automatic t_clear();
      logic [15:0] c;
      wr(qpc_pkg::A_START, 16'h0000);
      wr(qpc_pkg::A_MODE1, 16'h0084);
      wr(qpc_pkg::A_CNT1, 16'h0055);
      wr(qpc_pkg::A_CNT0, 16'h0000);
      wr(qpc_pkg::A_GR0A, 16'h0003);
      wr(qpc_pkg::A_GR0C, 16'h0007);
      wr(qpc_pkg::A_LINK, 16'h0006);
      wr(qpc_pkg::A_START, 16'h0003);
      repeat (20) @(posedge ref_clk);
      peek(qpc_pkg::A_CNT1, 16'h0000);
      peek(qpc_pkg::A_CAP1A, 16'h0000);
      peek(qpc_pkg::A_CAP1B, 16'h0000);
      rd(qpc_pkg::A_CNT0, c);
      chk({15'h0, c < 16'h0008}, 16'h0001);
   endtask

   // Normal mode with divide by one runs exactly two cycles between the start writes.
   task automatic t_norm();
      wr(qpc_pkg::A_START, 16'h0000);
      wr(qpc_pkg::A_STAT, 16'h00FF);
      wr(qpc_pkg::A_MODE2, 16'h0000);
      wr(qpc_pkg::A_CNT2, 16'hFFFE);
      wr(qpc_pkg::A_START, 16'h0004);
      wr(qpc_pkg::A_START, 16'h0000);
      peek(qpc_pkg::A_CNT2, 16'h0000);
      peek(qpc_pkg::A_STAT, 16'h0304);
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_submodes();
      t_wrap();
      t_link();
      t_clear();
      t_norm();
      test_done();
   end
endmodule
